// ---- core/cable_stp_consts.svh ----
// constants for the cable spanning-tree frame handler
`ifndef CABLE_STP_CONSTS_SVH
`define CABLE_STP_CONSTS_SVH

// dedicated multicast destination (value arbitrary, set per deployment)
`define CSTP_DEST_ADDR 48'h01_0a_0b_0c_0d_0e
// dedicated snap header (oui and type arbitrary, set per deployment)
`define CSTP_SNAP_HDR 64'haa_aa_03_00_12_34_56_78
// ordinary bridge group address and llc of the standard protocol
`define CSTP_STD_ADDR 48'h01_80_c2_00_00_00
`define CSTP_STD_LLC 24'h42_42_03

// frame layout, byte offsets
`define CSTP_DA_END 5'h05
`define CSTP_SA_END 5'h0b
`define CSTP_LEN_HI 5'h0c
`define CSTP_LEN_LO 5'h0d
`define CSTP_SNAP_END 5'h15
`define CSTP_BODY_OFS 6'h16
`define CSTP_TYPE_OFS 6'h19
`define CSTP_SNAP_LEN 16'h0008
`define CSTP_NOTICE_TYPE 8'h80

// bridge priorities and port costs
`define CSTP_PRIO_MODEM 16'h9000
`define CSTP_PRIO_HEADEND 16'h8000
`define CSTP_NETWORK_SIDE_COST 16'h000a
`define CSTP_COST_SCALE 32'h000f_4240
`define CSTP_COST_MAX 16'hffff

// default modem path costs, qpsk then 16qam
`define CSTP_COST_160_QPSK 16'h0c35
`define CSTP_COST_160_QAM16 16'h061b
`define CSTP_COST_320_QPSK 16'h061b
`define CSTP_COST_320_QAM16 16'h030d
`define CSTP_COST_640_QPSK 16'h030d
`define CSTP_COST_640_QAM16 16'h0187
`define CSTP_COST_1280_QPSK 16'h0187
`define CSTP_COST_1280_QAM16 16'h00c3
`define CSTP_COST_2560_QPSK 16'h00c3
`define CSTP_COST_2560_QAM16 16'h0062

// output port mask bits
`define CSTP_PORT_SUB 0
`define CSTP_PORT_NETWORK_SIDE 1
`define CSTP_PORT_RF 2

`endif

// ---- core/cable_stp_pkg.sv ----
// types for the cable spanning-tree frame handler
package cable_stp_pkg;

  typedef enum logic [1:0] {
    tx_idle,
    tx_head,
    tx_body,
    tx_drop
  } tx_state_t;

  typedef enum logic [2:0] {
    rate_160,
    rate_320,
    rate_640,
    rate_1280,
    rate_2560
  } rate_code_t;

endpackage

// ---- core/path_cost_table.sv ----
// path cost lookup and headend cost calculation
`timescale 1ns/1ps
`include "cable_stp_consts.svh"

module path_cost_table (
  input wire logic clock,
  input wire logic nrst,
  input wire logic is_headend,
  input wire logic [2:0] us_rate,
  input wire logic us_16qam,
  input wire logic [12:0] ds_ksym,
  input wire logic [3:0] ds_bits,
  output logic [15:0] cost
);

  // ****************************************
  // modem table and headend formula
  // ****************************************
  function automatic logic [15:0] modem_cost(input logic [2:0] rate,
                                             input logic qam16);
    logic [15:0] c;
    c = `CSTP_COST_MAX;
    unique case (cable_stp_pkg::rate_code_t'(rate))
      cable_stp_pkg::rate_160:
        c = qam16 ? `CSTP_COST_160_QAM16 : `CSTP_COST_160_QPSK;
      cable_stp_pkg::rate_320:
        c = qam16 ? `CSTP_COST_320_QAM16 : `CSTP_COST_320_QPSK;
      cable_stp_pkg::rate_640:
        c = qam16 ? `CSTP_COST_640_QAM16 : `CSTP_COST_640_QPSK;
      cable_stp_pkg::rate_1280:
        c = qam16 ? `CSTP_COST_1280_QAM16 : `CSTP_COST_1280_QPSK;
      cable_stp_pkg::rate_2560:
        c = qam16 ? `CSTP_COST_2560_QAM16 : `CSTP_COST_2560_QPSK;
      default:
        c = `CSTP_COST_MAX;
    endcase
    return c;
  endfunction

  logic [16:0] ds_prod;
  logic [31:0] ds_cost;

  // 1000 / (msym/s * bits) expressed with ksym/s
  always_comb begin
    ds_prod = 17'(ds_ksym) * 17'(ds_bits);
    ds_cost = (ds_prod == 17'h0) ? 32'h0000_ffff :
              `CSTP_COST_SCALE / {15'h0, ds_prod};
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cost <= `CSTP_COST_MAX;
    end else if (is_headend) begin
      cost <= (ds_cost > 32'h0000_ffff) ? `CSTP_COST_MAX :
              ds_cost[15:0];
    end else begin
      cost <= modem_cost(us_rate, us_16qam);
    end
  end

endmodule

// ---- core/cable_stp_framer.sv ----
// cable spanning-tree bpdu framer, filter and parameter source
`timescale 1ns/1ps
`include "cable_stp_consts.svh"

module cable_stp_framer (
  input wire logic clock,
  input wire logic nrst,
  input wire logic is_headend,
  input wire logic [47:0] own_mac,
  input wire logic tx_start,
  input wire logic [10:0] tx_len,
  input wire logic tx_is_notice,
  input wire logic tx_in_valid,
  input wire logic [7:0] tx_in_data,
  input wire logic tx_in_last,
  output logic tx_in_ready,
  output logic tx_busy,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  input wire logic out_ready,
  output logic [2:0] out_ports,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_upstream,
  output logic bpdu_valid,
  output logic [7:0] bpdu_data,
  output logic bpdu_last,
  output logic bpdu_accept,
  output logic fwd_valid,
  output logic [7:0] fwd_data,
  output logic fwd_last,
  output logic fwd_keep,
  output logic [15:0] std_drop_count,
  output logic [15:0] notice_drop_count,
  input wire logic [2:0] us_rate,
  input wire logic us_16qam,
  input wire logic [12:0] ds_ksym,
  input wire logic [3:0] ds_bits,
  input wire logic mgmt_prio_we,
  input wire logic [15:0] mgmt_prio,
  input wire logic mgmt_cost_we,
  input wire logic [15:0] mgmt_cost,
  output logic [15:0] bridge_priority,
  output logic [15:0] path_cost,
  output logic [15:0] network_side_port_cost
);

  // ****************************************
  // frame field helpers
  // ****************************************
  // {care, byte} expected at a header offset of a cable bpdu
  function automatic logic [8:0] cable_key(input logic [4:0] i);
    logic [47:0] da;
    logic [63:0] snap;
    logic [8:0] k;
    da = `CSTP_DEST_ADDR;
    snap = `CSTP_SNAP_HDR;
    k = 9'h000;
    if (i <= `CSTP_DA_END) begin
      k = {1'b1, da[8*(5-int'(i)) +: 8]};
    end else if (i > `CSTP_LEN_LO && i <= `CSTP_SNAP_END) begin
      k = {1'b1, snap[8*(21-int'(i)) +: 8]};
    end
    return k;
  endfunction

  // {care, byte} expected at a header offset of a standard bpdu
  function automatic logic [8:0] std_key(input logic [4:0] i);
    logic [47:0] da;
    logic [23:0] llc;
    logic [8:0] k;
    da = `CSTP_STD_ADDR;
    llc = `CSTP_STD_LLC;
    k = 9'h000;
    if (i <= `CSTP_DA_END) begin
      k = {1'b1, da[8*(5-int'(i)) +: 8]};
    end else if (i > `CSTP_LEN_LO && i < 5'h11) begin
      k = {1'b1, llc[8*(16-int'(i)) +: 8]};
    end
    return k;
  endfunction

  // ****************************************
  // transmit framing
  // ****************************************
  cable_stp_pkg::tx_state_t tx_state;
  logic [4:0] tx_idx;
  logic [15:0] tx_field_len;
  logic load_ok;
  logic [8:0] tx_key;
  logic [7:0] hdr_byte;

  always_comb begin
    load_ok = !out_valid || out_ready;
    tx_key = cable_key(tx_idx);
    if (tx_idx > `CSTP_DA_END && tx_idx <= `CSTP_SA_END) begin
      hdr_byte = own_mac[8*(11-int'(tx_idx)) +: 8];
    end else if (tx_idx == `CSTP_LEN_HI) begin
      hdr_byte = tx_field_len[15:8];
    end else if (tx_idx == `CSTP_LEN_LO) begin
      hdr_byte = tx_field_len[7:0];
    end else begin
      hdr_byte = tx_key[7:0];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_state <= cable_stp_pkg::tx_idle;
      tx_idx <= 5'h00;
      tx_field_len <= 16'h0000;
      tx_busy <= 1'b0;
      tx_in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= 8'h00;
      out_last <= 1'b0;
      out_ports <= 3'h0;
    end else begin
      if (out_valid && out_ready) begin
        out_valid <= 1'b0;
        out_last <= 1'b0;
      end
      unique case (tx_state)
        cable_stp_pkg::tx_idle: begin
          tx_idx <= 5'h00;
          if (tx_start) begin
            tx_busy <= 1'b1;
            tx_field_len <= 16'({5'h00, tx_len}) + `CSTP_SNAP_LEN;
            if (tx_is_notice) begin
              tx_state <= cable_stp_pkg::tx_drop;
              tx_in_ready <= 1'b1;
            end else begin
              tx_state <= cable_stp_pkg::tx_head;
              out_ports[`CSTP_PORT_SUB] <= !is_headend;
              out_ports[`CSTP_PORT_NETWORK_SIDE] <= is_headend;
              out_ports[`CSTP_PORT_RF] <= is_headend;
            end
          end
        end
        cable_stp_pkg::tx_head: begin
          if (load_ok) begin
            out_valid <= 1'b1;
            out_data <= hdr_byte;
            tx_idx <= tx_idx + 5'h01;
            if (tx_idx == `CSTP_SNAP_END) begin
              tx_state <= cable_stp_pkg::tx_body;
            end
          end
        end
        cable_stp_pkg::tx_body: begin
          if (tx_in_ready) begin
            if (tx_in_valid) begin
              tx_in_ready <= 1'b0;
              out_valid <= 1'b1;
              out_data <= tx_in_data;
              out_last <= tx_in_last;
              if (tx_in_last) begin
                tx_state <= cable_stp_pkg::tx_idle;
                tx_busy <= 1'b0;
              end
            end
          end else begin
            tx_in_ready <= load_ok;
          end
        end
        cable_stp_pkg::tx_drop: begin
          if (tx_in_valid && tx_in_last) begin
            tx_state <= cable_stp_pkg::tx_idle;
            tx_in_ready <= 1'b0;
            tx_busy <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************
  // receive classification
  // ****************************************
  logic [5:0] rx_idx;
  logic cable_ok;
  logic std_ok;
  logic is_notice;
  logic [8:0] rx_ckey;
  logic [8:0] rx_skey;
  logic cable_hit;
  logic std_hit;
  logic in_body;

  always_comb begin
    rx_ckey = cable_key(rx_idx[4:0]);
    rx_skey = std_key(rx_idx[4:0]);
    if (rx_idx[5]) begin
      rx_ckey = 9'h000;
      rx_skey = 9'h000;
    end
    cable_hit = cable_ok && (!rx_ckey[8] || rx_ckey[7:0] == rx_data);
    std_hit = std_ok && (!rx_skey[8] || rx_skey[7:0] == rx_data);
    in_body = rx_idx >= `CSTP_BODY_OFS;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_idx <= 6'h00;
      cable_ok <= 1'b1;
      std_ok <= 1'b1;
      is_notice <= 1'b0;
    end else if (rx_valid) begin
      if (rx_last) begin
        rx_idx <= 6'h00;
        cable_ok <= 1'b1;
        std_ok <= 1'b1;
        is_notice <= 1'b0;
      end else begin
        if (rx_idx != 6'h3f) begin
          rx_idx <= rx_idx + 6'h01;
        end
        cable_ok <= cable_hit;
        std_ok <= std_hit;
        if (rx_idx == `CSTP_TYPE_OFS) begin
          is_notice <= rx_data == `CSTP_NOTICE_TYPE;
        end
      end
    end
  end

  // payload to the engine; accept only a whole matching non-notice frame
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bpdu_valid <= 1'b0;
      bpdu_data <= 8'h00;
      bpdu_last <= 1'b0;
      bpdu_accept <= 1'b0;
    end else begin
      bpdu_valid <= rx_valid && in_body && cable_ok;
      bpdu_data <= rx_data;
      bpdu_last <= rx_valid && rx_last && in_body && cable_ok;
      bpdu_accept <= rx_valid && rx_last && cable_ok &&
                     rx_idx > `CSTP_TYPE_OFS && !is_notice;
    end
  end

  // headend mirror of upstream frames toward downstream
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fwd_valid <= 1'b0;
      fwd_data <= 8'h00;
      fwd_last <= 1'b0;
      fwd_keep <= 1'b0;
    end else begin
      fwd_valid <= rx_valid && rx_upstream && is_headend;
      fwd_data <= rx_data;
      fwd_last <= rx_valid && rx_last && rx_upstream && is_headend;
      fwd_keep <= rx_valid && rx_last && rx_upstream && is_headend &&
                  cable_ok && rx_idx > `CSTP_SNAP_END;
    end
  end

  // drop statistics
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      std_drop_count <= 16'h0000;
      notice_drop_count <= 16'h0000;
    end else if (rx_valid && rx_last) begin
      if (std_ok && rx_idx > `CSTP_TYPE_OFS) begin
        std_drop_count <= std_drop_count + 16'h0001;
      end
      if (cable_ok && rx_idx > `CSTP_TYPE_OFS && is_notice) begin
        notice_drop_count <= notice_drop_count + 16'h0001;
      end
    end
  end

  // ****************************************
  // bridge parameters
  // ****************************************
  logic [15:0] table_cost;
  logic prio_loaded;
  logic cost_override;

  path_cost_table u_cost (
    .clock(clock),
    .nrst(nrst),
    .is_headend(is_headend),
    .us_rate(us_rate),
    .us_16qam(us_16qam),
    .ds_ksym(ds_ksym),
    .ds_bits(ds_bits),
    .cost(table_cost)
  );

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bridge_priority <= `CSTP_PRIO_MODEM;
      prio_loaded <= 1'b0;
    end else if (mgmt_prio_we) begin
      bridge_priority <= mgmt_prio;
      prio_loaded <= 1'b1;
    end else if (!prio_loaded) begin
      bridge_priority <= is_headend ? `CSTP_PRIO_HEADEND :
                         `CSTP_PRIO_MODEM;
      prio_loaded <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      path_cost <= `CSTP_COST_MAX;
      cost_override <= 1'b0;
      network_side_port_cost <= `CSTP_NETWORK_SIDE_COST;
    end else begin
      network_side_port_cost <= `CSTP_NETWORK_SIDE_COST;
      if (mgmt_cost_we) begin
        path_cost <= mgmt_cost;
        cost_override <= 1'b1;
      end else if (!cost_override) begin
        path_cost <= table_cost;
      end
    end
  end

endmodule

// ---- bench/framer_properties.sv ----
// concurrent checks on the framer ports
`timescale 1ns/1ps
`include "cable_stp_consts.svh"
// ****
// port checker
// ****
module framer_properties (
  input wire logic clock,
  input wire logic nrst,
  input wire logic is_headend,
  input wire logic tx_start,
  input wire logic tx_is_notice,
  input wire logic tx_busy,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_ready,
  input wire logic [2:0] out_ports,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_upstream,
  input wire logic bpdu_valid,
  input wire logic [7:0] bpdu_data,
  input wire logic bpdu_accept,
  input wire logic fwd_valid,
  input wire logic [7:0] fwd_data,
  input wire logic mgmt_prio_we,
  input wire logic [15:0] mgmt_prio,
  input wire logic mgmt_cost_we,
  input wire logic [15:0] mgmt_cost,
  input wire logic [15:0] bridge_priority,
  input wire logic [15:0] path_cost,
  input wire logic [15:0] network_side_port_cost
);
  localparam logic [47:0] da = `CSTP_DEST_ADDR;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_tx_latency: assert property (
    tx_start && !tx_busy && !tx_is_notice |-> ##2
    (out_valid && out_data == da[47:40])) else $error("header byte late");
  a_notice_silent: assert property (
    tx_start && !tx_busy && tx_is_notice |=> !out_valid [*8])
    else $error("notice was sent");
  a_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data)
    && $stable(out_last)) else $error("output not held");
  a_ports_role: assert property (
    out_valid |-> out_ports == (is_headend ? 3'h6 : 3'h1))
    else $error("wrong output ports");
  a_fwd_copy: assert property (
    is_headend && rx_valid && rx_upstream |=>
    fwd_valid && fwd_data == $past(rx_data)) else $error("no forward");
  a_no_fwd_modem: assert property (
    !is_headend |-> !fwd_valid) else $error("modem forwarded");
  a_accept_cause: assert property (
    bpdu_accept |-> $past(rx_valid && rx_last)) else $error("bad accept");
  a_bpdu_bytes: assert property (
    bpdu_valid |-> $past(rx_valid) && bpdu_data == $past(rx_data))
    else $error("payload altered");
  a_side_port_cost: assert property (
    network_side_port_cost == 16'h000a) else $error("network port cost");
  a_prio_write: assert property (
    mgmt_prio_we |=> bridge_priority == $past(mgmt_prio))
    else $error("priority write lost");
  a_cost_write: assert property (
    mgmt_cost_we |=> path_cost == $past(mgmt_cost))
    else $error("cost write lost");
endmodule

bind cable_stp_framer framer_properties u_props (.clock, .nrst,
  .is_headend, .tx_start, .tx_is_notice, .tx_busy, .out_valid, .out_data,
  .out_last, .out_ready, .out_ports, .rx_valid, .rx_data, .rx_last,
  .rx_upstream, .bpdu_valid, .bpdu_data, .bpdu_accept, .fwd_valid,
  .fwd_data, .mgmt_prio_we, .mgmt_prio, .mgmt_cost_we, .mgmt_cost,
  .bridge_priority, .path_cost, .network_side_port_cost);

// ---- bench/peer_bridge.sv ----
// peer bridge model: sends received frames, sinks sent frames
`timescale 1ns/1ps
// ****
// peer model
// ****
module peer_bridge (
  input wire logic clock,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  output logic out_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic rx_upstream
);
  logic [7:0] got[$];
  logic got_last;
  bit slow;
  initial begin
    out_ready = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    rx_upstream = 1'b0;
    got_last = 1'b0;
    slow = 1'b0;
  end
  // collect sent bytes, stall at random when slow
  always @(posedge clock) begin
    if (out_valid && out_ready) begin
      got.push_back(out_data);
      if (out_last) got_last <= 1'b1;
    end
    out_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
  end
  // frames pass as plain data, data inverted once after the last byte
  task automatic send(input logic [7:0] b[$], input logic up);
    for (int i = 0; i < b.size(); i++) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data <= b[i];
      rx_last <= (i == b.size() - 1);
      rx_upstream <= up;
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
  endtask
endmodule

// ---- bench/cable_spanning_tree_bpdu_bench.sv ----
// self-checking bench for the cable spanning-tree framer
`timescale 1ns/1ps
`include "cable_stp_consts.svh"
module cable_spanning_tree_bpdu_bench;
  logic clock, nrst, is_headend, tx_start, tx_is_notice, tx_in_valid;
  logic tx_in_last, tx_in_ready, tx_busy, out_valid, out_last, out_ready;
  logic rx_valid, rx_last, rx_upstream, bpdu_valid, bpdu_last, bpdu_accept;
  logic fwd_valid, fwd_last, fwd_keep, us_16qam, mgmt_prio_we, mgmt_cost_we;
  logic [47:0] own_mac;
  logic [10:0] tx_len;
  logic [7:0] tx_in_data, out_data, rx_data, bpdu_data, fwd_data;
  logic [2:0] out_ports, us_rate;
  logic [12:0] ds_ksym;
  logic [3:0] ds_bits;
  logic [15:0] std_drop_count, notice_drop_count, mgmt_prio, mgmt_cost;
  logic [15:0] bridge_priority, path_cost, network_side_port_cost, v;
  logic [7:0] fr[$], exp_q[$];
  int error_cnt, checks_done, acc, nbpdu, keep, k, b, nlast, nfwd;
  localparam logic [15:0] ctab[10] = '{16'hc35, 16'h61b, 16'h61b,
    16'h30d, 16'h30d, 16'h187, 16'h187, 16'hc3, 16'hc3, 16'h62};
  cable_stp_framer DUT (.*);
  peer_bridge peer (.*);
  // ****
  // clock, monitor, helpers
  // ****
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (bpdu_valid) nbpdu++;
    if (bpdu_accept) acc++;
    if (fwd_keep) keep++;
    if (bpdu_last) nlast++;
    if (fwd_last) nfwd++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic void mk(output logic [7:0] f[$], input int kd, int n);
    logic [175:0] h;
    h = {(kd == 1) ? `CSTP_STD_ADDR : `CSTP_DEST_ADDR, 16'($urandom),
      $urandom, 16'(n + 8), (kd % 2) ? {`CSTP_STD_LLC, 40'h0} :
      `CSTP_SNAP_HDR};
    f = {};
    for (int i = 21; i >= 0; i--) f.push_back(h[i*8+:8]);
    for (int i = 0; i < n; i++)
      f.push_back(i != 3 ? 8'($urandom) : (kd == 2) ? 8'h80 : 8'h00);
  endfunction
  task automatic rst(input logic he);
    nrst <= 1'b0;
    is_headend <= he;
    repeat (10) @(posedge clock);
    chk(bridge_priority, 16'h9000);
    chk(network_side_port_cost, 16'h000a);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  task automatic tx_frame(input int n, input logic notice);
    logic [175:0] h;
    h = {`CSTP_DEST_ADDR, own_mac, 16'(n + 8), `CSTP_SNAP_HDR};
    exp_q = {};
    for (int i = 21; i >= 0; i--) exp_q.push_back(h[i*8+:8]);
    for (int i = 0; i < n; i++) exp_q.push_back(8'($urandom));
    peer.got = {};
    peer.got_last = 1'b0;
    @(posedge clock);
    tx_start <= 1'b1;
    tx_len <= 11'(n);
    tx_is_notice <= notice;
    @(posedge clock);
    tx_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      tx_in_valid <= 1'b1;
      tx_in_data <= exp_q[22 + i];
      tx_in_last <= (i == n - 1);
      k = 0;
      do begin @(posedge clock); k++; end while (!tx_in_ready && k < 300);
      if (k >= 300) error_cnt++;
    end
    tx_in_valid <= 1'b0;
    tx_in_last <= 1'b0;
    for (k = 0; !notice && !peer.got_last && k < 300; k++) @(posedge clock);
    if (k >= 300) error_cnt++;
    repeat (12) @(posedge clock);
    if (notice) exp_q = {};
    chk(peer.got.size(), exp_q.size());
    chk(tx_busy, 1'b0);
    foreach (exp_q[i])
      if (i < peer.got.size()) chk(peer.got[i], exp_q[i]);
  endtask
  task automatic rx_case(input int kd, input int n, input logic up);
    int a0, b0, k0, l0, f0;
    logic [15:0] s0, t0;
    mk(fr, kd, n);
    a0 = acc;
    b0 = nbpdu;
    k0 = keep;
    l0 = nlast;
    f0 = nfwd;
    s0 = std_drop_count;
    t0 = notice_drop_count;
    peer.send(fr, up);
    repeat (3) @(posedge clock);
    chk(acc - a0, kd == 0);
    chk(nbpdu - b0, (kd % 2) ? 0 : n);
    chk(nlast - l0, kd % 2 == 0);
    chk(std_drop_count - s0, kd == 1);
    chk(notice_drop_count - t0, kd == 2);
    chk(keep - k0, is_headend && up && kd % 2 == 0);
    chk(nfwd - f0, is_headend && up);
  endtask
  // ****
  // tests
  // ****
  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h8cbe));
    {nrst, is_headend, tx_start, tx_is_notice, tx_in_valid, tx_in_last} = 6'h0;
    {mgmt_prio_we, mgmt_cost_we, us_16qam, us_rate, ds_bits} = 10'h0;
    {tx_len, tx_in_data, ds_ksym, mgmt_prio, mgmt_cost} = 64'h0;
    own_mac = {16'($urandom), $urandom};
    rst(1'b0);
    for (int i = 0; i < 11; i++) begin
      us_rate <= (i < 10) ? 3'(i / 2) : 3'h7;
      us_16qam <= i[0];
      repeat (3) @(posedge clock);
      chk(path_cost, (i < 10) ? ctab[i] : 16'hffff);
    end
    chk(bridge_priority, 16'h9000);
    $display("test cost table done");
    for (int t = 0; t < 4; t++) begin
      peer.slow = t[0];
      tx_frame(t ? 1 + $urandom % 40 : 1, 1'b0);
    end
    tx_frame(5, 1'b1);
    $display("test transmit done");
    for (int kd = 0; kd < 4; kd++) rx_case(kd, 5 + $urandom % 20, 1'b1);
    $display("test receive done");
    rst(1'b1);
    chk(bridge_priority, 16'h8000);
    k = 1000 + $urandom % 4000;
    b = 4 + $urandom % 5;
    ds_ksym <= 13'(k);
    ds_bits <= 4'(b);
    repeat (3) @(posedge clock);
    chk(path_cost, 1000000 / (k * b));
    ds_bits <= 4'h0;
    repeat (3) @(posedge clock);
    chk(path_cost, 16'hffff);
    tx_frame(1 + $urandom % 30, 1'b0);
    rx_case(0, 8, 1'b1);
    rx_case(0, 8, 1'b0);
    rx_case(1, 8, 1'b1);
    $display("test headend done");
    for (int i = 0; i < 3; i++) begin
      v = (i == 2) ? 16'($urandom) : {16{i[0]}};
      mgmt_prio_we <= 1'b1;
      mgmt_prio <= v;
      mgmt_cost_we <= 1'b1;
      mgmt_cost <= ~v;
      @(posedge clock);
      mgmt_prio_we <= 1'b0;
      mgmt_cost_we <= 1'b0;
      ds_bits <= 4'h8;
      repeat (3) @(posedge clock);
      chk(bridge_priority, v);
      chk(path_cost, 16'(~v));
    end
    $display("test management done");
    wrap_up();
  end
endmodule
